//--- ssq_pkg.sv
// Package: constants and types of the measurement sequencer
package ssq_pkg;
	// ==========================================
	// Timing
	localparam int CLK_PS = 5000;
	localparam int MS_PS = 1000000000;
	localparam int CYC_PER_MS = MS_PS / CLK_PS;
	// ==========================================
	// Bus addresses and command words
	localparam logic [6:0] DEV_ADDR = 7'h44;
	localparam logic [6:0] GC_ADDR = 7'h00;
	localparam logic [7:0] GC_RESET = 8'h06;
	localparam logic [15:0] CMD_SOFT_RST = 16'h30a2;
	localparam logic [15:0] CMD_EXIT = 16'h3091;
	localparam logic [15:0] CMD_AUTO_1HZ = 16'h2130;
	localparam logic [7:0] RD_MSB = 8'he0;
	localparam logic [2:0] SEL_MEAS = 3'h0;
	localparam logic [2:0] SEL_TMIN = 3'h2;
	localparam logic [2:0] SEL_TMAX = 3'h3;
	localparam logic [2:0] SEL_HMIN = 3'h4;
	localparam logic [2:0] SEL_HMAX = 3'h5;
	// ==========================================
	// Codes: 130 C / 100 %RH full scale, -45 C / 0 %RH zero
	localparam logic [15:0] CODE_TOP = 16'hffff;
	localparam logic [15:0] CODE_BOT = 16'h0000;
	localparam logic [7:0] CRC_POLY = 8'h31;
	localparam logic [7:0] CRC_INIT = 8'hff;
	// Sampling periods in ms, indexed by rate code
	localparam logic [10:0] PER_R0 = 11'd2000;
	localparam logic [10:0] PER_R1 = 11'd1000;
	localparam logic [10:0] PER_R2 = 11'd500;
	localparam logic [10:0] PER_R3 = 11'd250;
	localparam logic [10:0] PER_R7 = 11'd100;
	// ==========================================
	// Types
	typedef enum logic [1:0] {
		M_SLEEP = 2'b00, M_SINGLE = 2'b01,
		M_AWAIT = 2'b10, M_ACONV = 2'b11
	} ssq_mode_e;
	typedef enum logic [2:0] {
		L_IDLE = 3'd0, L_ADDR = 3'd1, L_AACK = 3'd2,
		L_WR = 3'd3, L_WACK = 3'd4, L_RD = 3'd5,
		L_RACK = 3'd6
	} ssq_link_e;
	typedef struct packed {
		logic [15:0] temp;
		logic [15:0] humid;
	} ssq_meas_s;
	typedef struct packed {
		logic      ready;
		ssq_meas_s meas;
		ssq_meas_s lo;
		ssq_meas_s hi;
	} ssq_pub_s;
	typedef struct packed {
		logic       valid;
		logic       auto_m;
		logic [1:0] lp;
		logic [2:0] rate;
	} ssq_dec_s;
endpackage

//--- ssq_top.sv
// Measurement sequencer with bus target on its own link clock
`timescale 1ns/1ps
`default_nettype none
module ssq_top import ssq_pkg::*; #(
	parameter int CYC_MS = CYC_PER_MS
) (
	// Core clock and resets
	input  wire logic      clk,
	input  wire logic      rstn,
	input  wire logic      hw_reset_n_pin,
	// Bus pins, sampled on the link clock
	input  wire logic      link_clk,
	input  wire logic      scl_i,
	input  wire logic      sda_i,
	output logic           sda_o,
	output logic           sda_oe,
	// Converter front end
	output logic           conv_start,
	output logic           conv_abort,
	output logic [1:0]     conv_setting,
	input  wire logic      conv_done,
	input  wire ssq_meas_s conv_result,
	// Reload of calibration, offsets and limits
	output logic           cfg_reload
);
	initial begin
		if (CYC_MS < 1) $error("CYC_MS must be at least 1");
	end
	localparam logic [31:0] TICK_LAST = 32'(CYC_MS - 1);
	localparam ssq_meas_s CLR = '{CODE_TOP, CODE_TOP};

	// ==========================================
	// Functions
	function automatic ssq_dec_s decode(input logic [15:0] c);
		decode = '{1'b1, 1'b0, 2'd0, c[10:8]};
		case (c)
			16'h24ff: decode.lp = 2'd3;
			16'h2416, 16'h2c10: decode.lp = 2'd2;
			16'h240b, 16'h2c0d: decode.lp = 2'd1;
			16'h2400, 16'h2c06: decode.lp = 2'd0;
			16'h20ff, 16'h21ff, 16'h22ff, 16'h23ff, 16'h27ff:
				decode = '{1'b1, 1'b1, 2'd3, c[10:8]};
			16'h202f, 16'h212d, 16'h222b, 16'h2329, 16'h272a:
				decode = '{1'b1, 1'b1, 2'd2, c[10:8]};
			16'h2024, 16'h2126, 16'h2220, 16'h2322, 16'h2721:
				decode = '{1'b1, 1'b1, 2'd1, c[10:8]};
			16'h2032, CMD_AUTO_1HZ, 16'h2236, 16'h2334, 16'h2737:
				decode = '{1'b1, 1'b1, 2'd0, c[10:8]};
			default: decode.valid = 1'b0;
		endcase
	endfunction
	function automatic logic [10:0] per_ms(input logic [2:0] r);
		case (r)
			3'd0: per_ms = PER_R0;
			3'd1: per_ms = PER_R1;
			3'd2: per_ms = PER_R2;
			3'd3: per_ms = PER_R3;
			default: per_ms = PER_R7;
		endcase
	endfunction
	function automatic logic [7:0] crc8(input logic [15:0] d);
		logic [7:0] c;
		c = CRC_INIT;
		for (int i = 15; i >= 0; i--) begin
			c = (c[7] ^ d[i]) ? {c[6:0], 1'b0} ^ CRC_POLY : {c[6:0], 1'b0};
		end
		return c;
	endfunction
	function automatic logic [23:0] word3(input logic [15:0] v);
		return {v, crc8(v)};
	endfunction

	// ==========================================
	// Core: crossings into the clk domain
	logic [2:0]  pin_s_q;
	logic [2:0]  cmd_s_q;
	logic [2:0]  rd_s_q;
	logic [1:0]  pack_s_q;
	logic        l_cmd_t_q;
	logic        l_rd_t_q;
	logic        l_ack_q;
	logic [15:0] l_cmd_q;
	always_ff @(posedge clk) begin
		pin_s_q  <= {pin_s_q[1:0], hw_reset_n_pin};
		cmd_s_q  <= {cmd_s_q[1:0], l_cmd_t_q};
		rd_s_q   <= {rd_s_q[1:0], l_rd_t_q};
		pack_s_q <= {pack_s_q[0], l_ack_q};
	end

	// ==========================================
	// Core: command decode and sequencing terms
	ssq_mode_e  mode_q, mode_d;
	ssq_meas_s  meas_q, lo_q, hi_q;
	logic       ready_q;
	logic [1:0] lp_q;
	logic [10:0] per_q, ms_q;
	logic [31:0] tick_q;
	ssq_dec_s   dcd;
	// Command word is quasi-static: it changes only a whole frame later
	wire cmd_ev = cmd_s_q[2] ^ cmd_s_q[1];
	wire rd_ev = rd_s_q[2] ^ rd_s_q[1];
	assign dcd = decode(l_cmd_q);
	wire conv_busy = mode_q == M_SINGLE || mode_q == M_ACONV;
	wire is_srst = cmd_ev && l_cmd_q == CMD_SOFT_RST;
	wire is_exit = cmd_ev && l_cmd_q == CMD_EXIT;
	wire go_trig = cmd_ev && dcd.valid && !dcd.auto_m
		&& mode_q == M_SLEEP;
	wire go_auto = cmd_ev && dcd.valid && dcd.auto_m
		&& !conv_busy;
	wire tmr_hit = mode_q == M_AWAIT && ms_q >= per_q;
	wire start = go_trig || go_auto || tmr_hit;
	wire got = conv_done && conv_busy && !is_exit;
	wire upd_hist = got && mode_q == M_ACONV;
	wire rst_ev = !rstn || !pin_s_q[1] || is_srst;

	// Exit beats everything; a done in SINGLE returns to sleep
	assign mode_d = is_exit ? M_SLEEP
		: go_auto ? M_ACONV
		: go_trig ? M_SINGLE
		: tmr_hit ? M_ACONV
		: !got ? mode_q
		: mode_q == M_SINGLE ? M_SLEEP : M_AWAIT;
	wire ready_d = start ? 1'b0 : got ? 1'b1
		: (rd_ev && !mode_q[1]) ? 1'b0 : ready_q;
	// Readout in automatic mode leaves full-scale codes behind
	wire ssq_meas_s meas_d = got ? conv_result
		: (rd_ev && mode_q[1]) ? CLR : meas_q;
	wire ssq_meas_s lo_d = '{
		conv_result.temp < lo_q.temp ? conv_result.temp : lo_q.temp,
		conv_result.humid < lo_q.humid ? conv_result.humid : lo_q.humid};
	wire ssq_meas_s hi_d = '{
		conv_result.temp > hi_q.temp ? conv_result.temp : hi_q.temp,
		conv_result.humid > hi_q.humid ? conv_result.humid : hi_q.humid};

	// Sequencer state; every reset source lands here
	always_ff @(posedge clk) begin
		if (rst_ev) begin
			mode_q  <= M_SLEEP;
			ready_q <= 1'b0;
			meas_q  <= CLR;
		end else begin
			mode_q  <= mode_d;
			ready_q <= ready_d;
			meas_q  <= meas_d;
		end
	end
	// History: only a reset restores the start values
	always_ff @(posedge clk) begin
		if (rst_ev) begin
			lo_q <= '{CODE_TOP, CODE_TOP};
			hi_q <= '{CODE_BOT, CODE_BOT};
		end else if (upd_hist) begin
			lo_q <= lo_d;
			hi_q <= hi_d;
		end
	end
	// Period timer restarts with every conversion start
	wire tick_end = tick_q == TICK_LAST;
	always_ff @(posedge clk) begin
		if (rst_ev || start) begin
			tick_q <= '0;
			ms_q   <= '0;
		end else begin
			tick_q <= tick_end ? '0 : tick_q + 32'd1;
			ms_q   <= (tick_end && !tmr_hit) ? ms_q + 11'd1 : ms_q;
		end
	end
	// Front-end strobes and settings
	always_ff @(posedge clk) begin
		if (rst_ev) begin
			lp_q       <= '0;
			per_q      <= PER_R1;
			conv_start <= 1'b0;
			conv_abort <= 1'b0;
		end else begin
			lp_q       <= (go_trig || go_auto) ? dcd.lp : lp_q;
			per_q      <= go_auto ? per_ms(dcd.rate) : per_q;
			conv_start <= start;
			conv_abort <= is_exit && conv_busy;
		end
	end
	assign conv_setting = lp_q;
	// Reload pulse follows any reset; status and limits restore too
	always_ff @(posedge clk) cfg_reload <= rst_ev;

	// ==========================================
	// Core: publish a snapshot through a toggle handshake
	ssq_pub_s pub_q;
	logic     preq_q;
	wire ssq_pub_s live = '{ready_q, meas_q, lo_q, hi_q};
	wire pub_idle = preq_q == pack_s_q[1];
	always_ff @(posedge clk) begin
		if (!rstn) begin
			preq_q <= 1'b0;
			pub_q  <= '0;
		end else if (pub_idle && live != pub_q) begin
			preq_q <= !preq_q;
			pub_q  <= live;
		end
	end

	// ==========================================
	// Link: reset and pin synchronisers
	logic [1:0] lrst_s_q;
	logic [2:0] scl_s_q, sda_s_q;
	logic [1:0] preq_s_q;
	always_ff @(posedge link_clk) begin
		lrst_s_q <= {lrst_s_q[0], rstn};
		scl_s_q  <= {scl_s_q[1:0], scl_i};
		sda_s_q  <= {sda_s_q[1:0], sda_i};
		preq_s_q <= {preq_s_q[0], preq_q};
	end
	wire l_rst = !lrst_s_q[1];
	wire scl_r = scl_s_q[1] && !scl_s_q[2];
	wire scl_f = !scl_s_q[1] && scl_s_q[2];
	wire sda_now = sda_s_q[1];
	wire st_ev = scl_s_q[1] && scl_s_q[2] && sda_s_q[2] && !sda_now;
	wire sp_ev = scl_s_q[1] && scl_s_q[2] && !sda_s_q[2] && sda_now;

	// ==========================================
	// Link: target state machine
	ssq_link_e   lst_q;
	ssq_pub_s    l_pub_q;
	logic [3:0]  cnt_q;
	logic [7:0]  sh_q, w0_q, w1_q;
	logic [1:0]  wb_q;
	logic [2:0]  sel_q, bidx_q;
	logic [47:0] tx_q;
	logic        rw_q, gc_q, ack_q, mack_q;
	wire is_dev = sh_q[7:1] == DEV_ADDR;
	wire is_gc = sh_q[7:1] == GC_ADDR && !sh_q[0];
	wire hist_sel = sel_q >= SEL_TMIN && sel_q <= SEL_HMAX;
	wire rd_ok = sel_q == SEL_MEAS ? l_pub_q.ready : hist_sel;
	wire addr_ack = is_dev && (!sh_q[0] || rd_ok) || is_gc;
	wire in_wr = (lst_q == L_WR || lst_q == L_WACK) && !rw_q;
	wire fire = (st_ev || sp_ev) && in_wr && (gc_q
		? wb_q != 2'd0 && w0_q == GC_RESET : wb_q == 2'd2);
	wire [15:0] fire_w = gc_q ? CMD_SOFT_RST : {w0_q, w1_q};
	wire [2:0] fire_sel = w0_q == RD_MSB ? w1_q[2:0] : SEL_MEAS;
	// Frame: two words each with its checksum, or one padded word
	wire [47:0] frame = sel_q == SEL_TMIN ? {word3(l_pub_q.lo.temp), 24'hffffff}
		: sel_q == SEL_TMAX ? {word3(l_pub_q.hi.temp), 24'hffffff}
		: sel_q == SEL_HMIN ? {word3(l_pub_q.lo.humid), 24'hffffff}
		: sel_q == SEL_HMAX ? {word3(l_pub_q.hi.humid), 24'hffffff}
		: {word3(l_pub_q.meas.temp), word3(l_pub_q.meas.humid)};
	wire last_meas = sel_q == SEL_MEAS && bidx_q == 3'd5;

	// Snapshot capture: data stands still while the toggles differ
	always_ff @(posedge link_clk) begin
		if (l_rst) begin
			l_ack_q <= 1'b0;
			l_pub_q <= '0;
		end else if (preq_s_q[1] != l_ack_q) begin
			l_ack_q <= preq_s_q[1];
			l_pub_q <= pub_q;
		end
	end
	// Completed writes become one command event for the core
	always_ff @(posedge link_clk) begin
		if (l_rst) begin
			l_cmd_t_q <= 1'b0;
			l_cmd_q   <= '0;
			sel_q     <= SEL_MEAS;
		end else if (fire) begin
			l_cmd_t_q <= !l_cmd_t_q;
			l_cmd_q   <= fire_w;
			sel_q     <= gc_q ? SEL_MEAS : fire_sel;
		end
	end
	// Bit engine: sample on rising SCL, drive after falling SCL
	always_ff @(posedge link_clk) begin
		if (l_rst || sp_ev) begin
			lst_q  <= L_IDLE;
			sda_oe <= 1'b0;
			cnt_q  <= '0;
			// A stop must not disturb the readout toggle, only a reset
			l_rd_t_q <= l_rst ? 1'b0 : l_rd_t_q;
		end else if (st_ev) begin
			lst_q  <= L_ADDR;
			sda_oe <= 1'b0;
			cnt_q  <= '0;
			wb_q   <= '0;
		end else if (scl_r) begin
			sh_q   <= {sh_q[6:0], sda_now};
			cnt_q  <= cnt_q + 4'd1;
			mack_q <= !sda_now;
		end else if (scl_f) begin
			unique case (lst_q)
				L_ADDR: if (cnt_q == 4'd8) begin
					lst_q  <= L_AACK;
					rw_q   <= sh_q[0];
					gc_q   <= is_gc;
					ack_q  <= addr_ack;
					sda_oe <= addr_ack;
				end
				L_WR: if (cnt_q == 4'd8) begin
					lst_q  <= L_WACK;
					sda_oe <= 1'b1;
					w0_q   <= wb_q == 2'd0 ? sh_q : w0_q;
					w1_q   <= wb_q == 2'd1 ? sh_q : w1_q;
					wb_q   <= wb_q == 2'd3 ? wb_q : wb_q + 2'd1;
				end
				L_AACK, L_WACK: begin
					lst_q  <= !ack_q ? L_IDLE : rw_q ? L_RD : L_WR;
					sda_oe <= ack_q && rw_q && !frame[47];
					tx_q   <= {frame[46:0], 1'b1};
					cnt_q  <= '0;
					bidx_q <= '0;
				end
				L_RD: if (cnt_q == 4'd8) begin
					lst_q    <= L_RACK;
					sda_oe   <= 1'b0;
					bidx_q   <= bidx_q + 3'd1;
					l_rd_t_q <= last_meas ? !l_rd_t_q : l_rd_t_q;
				end else begin
					sda_oe <= !tx_q[47];
					tx_q   <= {tx_q[46:0], 1'b1};
				end
				L_RACK: begin
					lst_q  <= mack_q ? L_RD : L_IDLE;
					sda_oe <= mack_q && !tx_q[47];
					tx_q   <= {tx_q[46:0], 1'b1};
					cnt_q  <= '0;
				end
				default: ;
			endcase
		end
	end
	// Open drain: the pin is only ever pulled low
	assign sda_o = 1'b0;

	// ==========================================
	// Checks
	a_reset_sleep: assert property (@(posedge clk)
		rst_ev |=> mode_q == M_SLEEP && !ready_q)
		else $error("reset did not enter sleep");
	a_hist_start: assert property (@(posedge clk)
		rst_ev |=> lo_q.temp == CODE_TOP && hi_q.humid == CODE_BOT)
		else $error("history start values wrong");
	a_hist_frozen: assert property (@(posedge clk) disable iff (!rstn)
		!upd_hist && !rst_ev |=> $stable(lo_q) && $stable(hi_q))
		else $error("history moved outside automatic mode");
	a_single_seq: assert property (@(posedge clk) disable iff (rst_ev)
		go_trig |=> conv_start && mode_q == M_SINGLE)
		else $error("trigger did not start conversion");
	a_single_end: assert property (@(posedge clk) disable iff (rst_ev)
		got && mode_q == M_SINGLE |=> mode_q == M_SLEEP && ready_q)
		else $error("single conversion did not end in sleep");
	a_exit_abort: assert property (@(posedge clk) disable iff (rst_ev)
		is_exit && mode_q == M_ACONV |=> conv_abort && mode_q == M_SLEEP)
		else $error("exit did not abort");
	a_read_clear: assert property (@(posedge clk) disable iff (rst_ev)
		rd_ev && mode_q[1] && !got |=> meas_q == CLR)
		else $error("result not cleared after read");
	a_auto_repeat: assert property (@(posedge clk) disable iff (rst_ev)
		tmr_hit && !cmd_ev |=> conv_start ##1 !conv_start)
		else $error("automatic period did not restart");
	a_nack_busy: assert property (@(posedge link_clk) disable iff (l_rst)
		lst_q == L_ADDR && scl_f && cnt_q == 4'd8 && !st_ev && !sp_ev
		&& is_dev && sh_q[0] && sel_q == SEL_MEAS && !l_pub_q.ready
		|=> !sda_oe)
		else $error("read acknowledged while busy");
	c_single: cover property (@(posedge clk) go_trig ##[1:1000] got);
	c_auto: cover property (@(posedge clk) upd_hist ##1 tmr_hit);
	c_exit: cover property (@(posedge clk) is_exit && conv_busy);
endmodule // ssq_top
`default_nettype wire

//--- ssq_ctrl_model.sv
// Bus controller model that drives the sequencer's two-wire pins
`timescale 1ns/1ps
`default_nettype none
module ssq_ctrl_model (
	// Link clock and resolved data line
	input  wire logic link_clk,
	input  wire logic sda_in,
	// Clock pin and open-drain pull on data
	output logic      scl,
	output logic      sda_low,
	// One strobe per ack bit or read byte seen
	output logic      res_stb,
	output logic [8:0] res
);
	// ==========================================
	// Timing: SCL low 8 and high 4 link cycles, data set 7 before rise
	localparam int T_LO = 8;
	localparam int T_HI = 4;
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
		res_stb = 1'b0;
		res = 9'h000;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge link_clk);
	endtask
	task automatic report(input logic [8:0] v);
		res <= v;
		res_stb <= 1'b1;
		tick(1);
		res_stb <= 1'b0;
	endtask
	// Data moves one cycle after SCL falls, so the target's hold is met
	task automatic bit_x(input logic lo, output logic seen);
		tick(1);
		sda_low <= lo;
		tick(T_LO - 1);
		scl <= 1'b1;
		tick(T_HI);
		seen = sda_in;
		scl <= 1'b0;
	endtask
	// ==========================================
	// Frame pieces
	task automatic start();
		tick(T_LO);
		if (scl === 1'b0) begin
			sda_low <= 1'b0;
			tick(T_LO);
			scl <= 1'b1;
			tick(T_HI);
		end
		sda_low <= 1'b1;
		tick(T_HI);
		scl <= 1'b0;
	endtask
	// Returns at once so the bench sees pulses caused by the stop
	task automatic stop();
		tick(1);
		sda_low <= 1'b1;
		tick(T_LO - 1);
		scl <= 1'b1;
		tick(T_HI);
		sda_low <= 1'b0;
	endtask
	task automatic wbyte(input logic [7:0] b);
		logic a;
		for (int i = 7; i >= 0; i--)
			bit_x(~b[i], a);
		bit_x(1'b0, a);
		report({1'b1, 7'h00, a});
	endtask
	task automatic rbyte(input logic nack);
		logic [7:0] v;
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b0, s);
			v[i] = s;
		end
		bit_x(~nack, s);
		report({1'b0, v});
	endtask
endmodule // ssq_ctrl_model
`default_nettype wire

//--- tb_sensor_measure_sequencer.sv
// Self-checking bench for the measurement sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_sensor_measure_sequencer import ssq_pkg::*; ;
	// ==========================================
	// Signals; a short millisecond keeps the 1 s period affordable
	localparam int CMS = 30;
	localparam int PER = 1000 * CMS;
	localparam logic [15:0] TRIG [0:3] = '{16'h2400, 16'h2c06, 16'h240b,
		16'h2c0d};
	localparam logic [1:0] TSET [0:3] = '{2'h0, 2'h0, 2'h1, 2'h1};
	localparam logic [7:0] AM [0:4] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h27};
	localparam logic [7:0] AL [0:19] = '{8'h32, 8'h24, 8'h2f, 8'hff, 8'h30,
		8'h26, 8'h2d, 8'hff, 8'h36, 8'h20, 8'h2b, 8'hff, 8'h34, 8'h22,
		8'h29, 8'hff, 8'h37, 8'h21, 8'h2a, 8'hff};
	logic        clk, rstn, hw_reset_n_pin, link_clk, conv_done;
	logic        sda_o, sda_oe, scl, sda_low, res_stb;
	logic        conv_start, conv_abort, cfg_reload;
	logic [1:0]  conv_setting;
	logic [8:0]  res;
	logic [8:0]  expq [$];
	logic [31:0] rs;
	ssq_meas_s   conv_result, fe_res;
	int          err_count, cmp_count, fe_lat, t0;
	int          cyc = 0;
	wire         sda_line = !(sda_low || (sda_oe === 1'b1 && sda_o === 1'b0));
	wire [3:0]   evs = {conv_done, cfg_reload, conv_abort, conv_start};
	ssq_top #(.CYC_MS(CMS)) ssq_top_i (
		.clk(clk), .rstn(rstn), .hw_reset_n_pin(hw_reset_n_pin),
		.link_clk(link_clk), .scl_i(scl), .sda_i(sda_line),
		.sda_o(sda_o), .sda_oe(sda_oe), .conv_start(conv_start),
		.conv_abort(conv_abort), .conv_setting(conv_setting),
		.conv_done(conv_done), .conv_result(conv_result),
		.cfg_reload(cfg_reload)
	);
	ssq_ctrl_model ssq_ctrl_model_i (
		.link_clk(link_clk), .sda_in(sda_line), .scl(scl),
		.sda_low(sda_low), .res_stb(res_stb), .res(res)
	);
	// Clocks in unrelated phase
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		link_clk = 1'b0;
		#7;
		forever #24 link_clk = ~link_clk;
	end
	always @(posedge clk) cyc <= cyc + 1;
	// ==========================================
	// Helpers
	function automatic logic [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction
	function automatic logic [7:0] crc8(input logic [15:0] w);
		logic [7:0] c;
		c = CRC_INIT;
		for (int i = 15; i >= 0; i--)
			c = (c[7] ^ w[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
		return c;
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		cmp_count++;
		if (seen !== want) begin
			err_count++;
			$display("BAD t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask
	task automatic test_done();
		$display("errors=%0d compares=%0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Bounded wait for one event line, seen at a rising edge
	task automatic wait_ev(input int k, input int lim);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (evs[k] !== 1'b1 && n < lim);
		if (n >= lim) begin
			err_count++;
			test_done();
		end
	endtask
	task automatic wb(input logic [7:0] b, input logic nack);
		expq.push_back({1'b1, 7'h00, nack});
		ssq_ctrl_model_i.wbyte(b);
	endtask
	task automatic wr_cmd(input logic [15:0] c);
		ssq_ctrl_model_i.start();
		wb({DEV_ADDR, 1'b0}, 1'b0);
		wb(c[15:8], 1'b0);
		wb(c[7:0], 1'b0);
		ssq_ctrl_model_i.stop();
	endtask
	// Optional pointer write, then n bytes; n of 0 expects a refused address
	task automatic rd(input logic [15:0] ptr, input int n,
		input logic [15:0] a, input logic [15:0] b);
		logic [7:0] q [0:5];
		q = '{a[15:8], a[7:0], crc8(a), b[15:8], b[7:0], crc8(b)};
		ssq_ctrl_model_i.start();
		if (ptr !== 16'h0000) begin
			wb({DEV_ADDR, 1'b0}, 1'b0);
			wb(ptr[15:8], 1'b0);
			wb(ptr[7:0], 1'b0);
			ssq_ctrl_model_i.start();
		end
		wb({DEV_ADDR, 1'b1}, n == 0);
		for (int i = 0; i < n; i++) begin
			expq.push_back({1'b0, q[i]});
			ssq_ctrl_model_i.rbyte(i == n - 1);
		end
		ssq_ctrl_model_i.stop();
	endtask
	// ==========================================
	// Checker: each bus result against the oldest note
	always @(posedge link_clk) begin
		if (res_stb === 1'b1) begin
			if (expq.size() == 0)
				check({7'h00, res}, 16'hdead);
			else
				check({7'h00, res}, {7'h00, expq.pop_front()});
		end
	end
	// Converter front end: answers a start after fe_lat unless aborted
	initial begin
		conv_done = 1'b0;
		conv_result = '0;
		forever begin
			@(posedge clk);
			if (conv_start === 1'b1) begin
				for (int k = 0; k < fe_lat && conv_abort !== 1'b1; k++)
					@(posedge clk);
				if (conv_abort !== 1'b1) begin
					conv_result <= fe_res;
					conv_done <= 1'b1;
					@(posedge clk);
					conv_done <= 1'b0;
				end
			end
		end
	end
	// ==========================================
	// Main sequence; reset spans enough link edges for its synchroniser
	initial begin
		rs = 32'h9d77;
		rstn = 1'b0;
		hw_reset_n_pin = 1'b1;
		fe_lat = 50;
		fe_res = '0;
		repeat (40) @(posedge clk);
		check({15'h0, cfg_reload}, 16'h1);
		rstn <= 1'b1;
		repeat (100) @(posedge clk);
		rd(16'h0000, 0, 16'h0, 16'h0);
		for (int j = 0; j < 4; j++) begin
			fe_res = rnd();
			fe_lat = (j == 0) ? 6000 : 50;
			wr_cmd(TRIG[j]);
			wait_ev(0, 200);
			check({14'h0, conv_setting}, {14'h0, TSET[j]});
			if (j == 0)
				rd(16'h0000, 0, 16'h0, 16'h0);
			wait_ev(3, 7000);
		end
		rd(16'h0000, 6, fe_res.temp, fe_res.humid);
		rd(16'h0000, 0, 16'h0, 16'h0);
		rd(16'he003, 3, CODE_BOT, 16'h0);
		rd(16'he004, 3, CODE_TOP, 16'h0);
		rd(16'he005, 3, CODE_BOT, 16'h0);
		// Automatic mode at one per second, cleared readout, then exit
		fe_res = rnd();
		fe_lat = 50;
		wr_cmd(CMD_AUTO_1HZ);
		wait_ev(0, 200);
		t0 = cyc;
		check({14'h0, conv_setting}, 16'h0);
		wait_ev(3, 100);
		rd(16'he000, 6, fe_res.temp, fe_res.humid);
		rd(16'he000, 6, CODE_TOP, CODE_TOP);
		fe_lat = 9000;
		wait_ev(0, PER);
		check({15'h0, cyc - t0 > PER - 100 && cyc - t0 < PER + 100}, 16'h1);
		wr_cmd(CMD_EXIT);
		wait_ev(1, 200);
		rd(16'he002, 3, fe_res.temp, 16'h0);
		// The three reset sources that reach the core while running
		wr_cmd(CMD_SOFT_RST);
		wait_ev(2, 200);
		rd(16'he002, 3, CODE_TOP, 16'h0);
		ssq_ctrl_model_i.start();
		wb({GC_ADDR, 1'b0}, 1'b0);
		wb(GC_RESET, 1'b0);
		ssq_ctrl_model_i.stop();
		wait_ev(2, 200);
		@(posedge clk);
		hw_reset_n_pin <= 1'b0;
		wait_ev(2, 10);
		repeat (4) @(posedge clk);
		hw_reset_n_pin <= 1'b1;
		repeat (100) @(posedge clk);
		rd(16'h0000, 0, 16'h0, 16'h0);
		// Every automatic enable code and its conversion setting
		fe_lat = 50;
		for (int i = 0; i < 20; i++) begin
			wr_cmd({AM[i / 4], AL[i]});
			wait_ev(0, 200);
			check({14'h0, conv_setting}, {14'h0, i[1:0]});
		end
		wr_cmd(CMD_EXIT);
		repeat (100) @(posedge clk);
		check(16'(expq.size()), 16'h0);
		test_done();
	end
	// Hang guard
	initial begin
		repeat (400000) @(posedge clk);
		err_count++;
		test_done();
	end
endmodule // tb_sensor_measure_sequencer
`default_nettype wire
